/* File: hdl/fcs_defs.vh */
// constants for the flash command/status host controller
// assumes a 25 MHz clk and a flash part driven by plain async strobes
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH

// software register offsets (4-bit word index)
`define FCS_REG_CTRL 4'h0
`define FCS_REG_ADDR_LO 4'h1
`define FCS_REG_ADDR_HI 4'h2
`define FCS_REG_WDATA 4'h3
`define FCS_REG_RDATA 4'h4
`define FCS_REG_STAT 4'h5
`define FCS_REG_PINS 4'h6

// operation codes written to CTRL[3:0]
`define FCS_OP_WRITE 4'h0
`define FCS_OP_READ 4'h1
`define FCS_OP_PROG 4'h2
`define FCS_OP_CANCEL 4'h3
`define FCS_OP_ERASE 4'h4
`define FCS_OP_SUSP 4'h5
`define FCS_OP_RESUME 4'h6
`define FCS_OP_CLEAR 4'h7
`define FCS_OP_ARRAY 4'h8
`define FCS_OP_STATUS 4'h9
`define FCS_OP_IDENT 4'hA

// flash command bytes
`define FCS_CMD_ARRAY 16'h00FF
`define FCS_CMD_IDENT 16'h0090
`define FCS_CMD_STATUS 16'h0070
`define FCS_CMD_CLEAR 16'h0050
`define FCS_CMD_ERASE 16'h0020
`define FCS_CMD_CONFIRM 16'h00D0
`define FCS_CMD_PROG 16'h0040
`define FCS_CMD_SUSP 16'h00B0
`define FCS_NULL_BYTE 16'h00FF
`define FCS_NULL_WORD 16'hFFFF

// status bit positions
`define FCS_SR_READY 7
`define FCS_SR_SUSP 6
`define FCS_SR_WIPE 5
`define FCS_SR_PROG 4
`define FCS_SR_SUPPLY 3

// PINS register fields and reset value
`define FCS_PIN_WORD 0
`define FCS_PIN_VPP 1
`define FCS_PIN_WP 2
`define FCS_PIN_RP 3
`define FCS_PIN_HV 4
`define FCS_PINS_RESET 5'h09

// timing: figures in ns, counts in cycles (least times round up)
`define FCS_CLK_NS 40
`define FCS_STROBE_NS 80
`define FCS_RECOVER_NS 40
`define FCS_STROBE_CYC ((`FCS_STROBE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_RECOVER_CYC ((`FCS_RECOVER_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_SYNC_CYC 3

`endif

/* File: hdl/fcs_ctrl.v */
// host-side controller issuing command sequences to a boot-block flash
// assumes software on the plain register port, flash pins on the far side
`include "fcs_defs.vh"

// Notes on behaviour
// - array read after reset; FFh returns
// - program is setup then address/data write
// - all-ones data after setup cancels program
// - boot block needs supply plus override/unlock
// - erase is 20h then D0h in block
module fcs_ctrl (
  input wire clk,
  input wire rst,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  output reg flash_ce_n,
  output reg flash_we_n,
  output reg flash_oe_n,
  output reg [17:0] flash_addr,
  output reg [15:0] flash_dq_o,
  output reg flash_dq_oe,
  input wire [15:0] flash_dq_i,
  output reg flash_byte_n,
  output reg flash_rp_n,
  output reg flash_rp_hv,
  output reg flash_vpp_en,
  output reg flash_wp
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SET = 2'h1;
  localparam ST_ACT = 2'h2;
  localparam ST_REC = 2'h3;
  localparam STEP_POLL = 2'h2;

  reg [1:0] st_q;
  reg [1:0] step_q;
  reg [3:0] op_q;
  reg [2:0] cnt_q;
  reg busy_q;
  reg err_q;
  reg refused_q;
  reg done_q;
  reg [7:0] srd_q;
  reg [15:0] rword_q;
  reg [15:0] addr_lo_q;
  reg [1:0] addr_hi_q;
  reg [15:0] wdata_q;
  reg [4:0] pins_q;
  reg [15:0] dq_s1_q;
  reg [15:0] dq_s2_q;
  reg [15:0] dq_s3_q;

  reg cyc_rd;
  reg cyc_end;
  reg cyc_poll;
  reg [15:0] cyc_dat;
  reg hv_op;

  wire start = reg_wr && (reg_addr == `FCS_REG_CTRL);
  wire stable = (dq_s2_q == dq_s3_q);

  //////////////////////////////////////////////////////////////////////////
  // per-op cycle table: which bus cycle the current step issues
  always @* begin
    cyc_rd = 1'b0;
    cyc_end = 1'b1;
    cyc_poll = 1'b0;
    cyc_dat = `FCS_CMD_ARRAY;
    case (op_q)
      `FCS_OP_WRITE: begin
        cyc_dat = wdata_q;
      end
      `FCS_OP_READ: begin
        cyc_rd = 1'b1;
      end
      `FCS_OP_PROG: begin
        // setup then target data, back to back; then poll
        cyc_end = (step_q != 2'h0);
        cyc_dat = (step_q == 2'h0) ? `FCS_CMD_PROG : wdata_q;
        cyc_poll = 1'b1;
      end
      `FCS_OP_CANCEL: begin
        // null program: width of all-ones follows the bus mode
        cyc_end = (step_q != 2'h0);
        cyc_dat = (step_q == 2'h0) ? `FCS_CMD_PROG :
          (pins_q[`FCS_PIN_WORD] ? `FCS_NULL_WORD : `FCS_NULL_BYTE);
      end
      `FCS_OP_ERASE: begin
        // address register must lie in the block to wipe
        cyc_end = (step_q != 2'h0);
        cyc_dat = (step_q == 2'h0) ? `FCS_CMD_ERASE : `FCS_CMD_CONFIRM;
        cyc_poll = 1'b1;
      end
      `FCS_OP_SUSP: begin
        cyc_dat = `FCS_CMD_SUSP;
        cyc_poll = 1'b1;
      end
      `FCS_OP_RESUME: begin
        cyc_dat = `FCS_CMD_CONFIRM;
      end
      `FCS_OP_CLEAR: begin
        cyc_dat = `FCS_CMD_CLEAR;
      end
      `FCS_OP_ARRAY: begin
        cyc_dat = `FCS_CMD_ARRAY;
      end
      `FCS_OP_STATUS: begin
        cyc_end = (step_q != 2'h0);
        cyc_rd = (step_q != 2'h0);
        cyc_dat = `FCS_CMD_STATUS;
      end
      `FCS_OP_IDENT: begin
        // low address bit in ADDR_LO selects maker or part code
        cyc_end = (step_q != 2'h0);
        cyc_rd = (step_q != 2'h0);
        cyc_dat = `FCS_CMD_IDENT;
      end
      default: begin
        cyc_dat = `FCS_CMD_ARRAY;
      end
    endcase
    if (step_q == STEP_POLL) begin
      cyc_rd = 1'b1;
    end
  end

  // ops that need the raised program supply
  always @* begin
    hv_op = 1'b0;
    case (op_q)
      `FCS_OP_PROG: hv_op = 1'b1;
      `FCS_OP_CANCEL: hv_op = 1'b1;
      `FCS_OP_ERASE: hv_op = 1'b1;
      `FCS_OP_SUSP: hv_op = 1'b1;
      `FCS_OP_RESUME: hv_op = 1'b1;
      default: hv_op = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // data pins come from an async part: three stages, two must agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      dq_s3_q <= 16'h0000;
    end else begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software-written configuration registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_lo_q <= 16'h0000;
      addr_hi_q <= 2'h0;
      wdata_q <= 16'h0000;
      pins_q <= `FCS_PINS_RESET;
    end else if (reg_wr && !busy_q) begin
      // held still while busy so both cycles see one address
      case (reg_addr)
        `FCS_REG_ADDR_LO: addr_lo_q <= reg_wdata;
        `FCS_REG_ADDR_HI: addr_hi_q <= reg_wdata[1:0];
        `FCS_REG_WDATA: wdata_q <= reg_wdata;
        `FCS_REG_PINS: pins_q <= reg_wdata[4:0];
        default: addr_hi_q <= addr_hi_q;
      endcase
    end
  end

  // pin levels; supply raised for the whole high-voltage op
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_byte_n <= 1'b1;
      flash_rp_n <= 1'b0;
      flash_rp_hv <= 1'b0;
      flash_vpp_en <= 1'b0;
      flash_wp <= 1'b0;
      flash_addr <= 18'h00000;
    end else begin
      flash_byte_n <= pins_q[`FCS_PIN_WORD];
      flash_rp_n <= pins_q[`FCS_PIN_RP];
      flash_rp_hv <= pins_q[`FCS_PIN_HV];
      flash_wp <= pins_q[`FCS_PIN_WP];
      flash_vpp_en <= pins_q[`FCS_PIN_VPP] | (busy_q & hv_op);
      flash_addr <= {addr_hi_q, addr_lo_q};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer: setup, strobe, recovery, per step
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      step_q <= 2'h0;
      op_q <= `FCS_OP_ARRAY;
      cnt_q <= 3'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      srd_q <= 8'h00;
      rword_q <= 16'h0000;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_dq_o <= 16'h0000;
      flash_dq_oe <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            op_q <= reg_wdata[3:0];
            step_q <= 2'h0;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            st_q <= ST_SET;
          end
        end
        ST_SET: begin
          // address and data settle before the strobe falls
          flash_ce_n <= 1'b0;
          flash_dq_o <= cyc_dat;
          flash_dq_oe <= !cyc_rd;
          cnt_q <= 3'h0;
          st_q <= ST_ACT;
        end
        ST_ACT: begin
          flash_we_n <= cyc_rd;
          flash_oe_n <= !cyc_rd;
          cnt_q <= cnt_q + 3'h1;
          if (!cyc_rd && cnt_q >= `FCS_STROBE_CYC) begin
            flash_we_n <= 1'b1; // data latch on the rising edge
            cnt_q <= 3'h0;
            st_q <= ST_REC;
          end else if (cyc_rd && stable &&
              cnt_q >= (`FCS_STROBE_CYC + `FCS_SYNC_CYC)) begin
            // sample only once the synchronised word holds still
            rword_q <= dq_s3_q;
            srd_q <= {dq_s3_q[7:3], 3'h0};
            flash_oe_n <= 1'b1;
            cnt_q <= 3'h0;
            st_q <= ST_REC;
          end
        end
        ST_REC: begin
          flash_ce_n <= 1'b1;
          flash_dq_oe <= 1'b0;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q >= (`FCS_RECOVER_CYC - 1)) begin
            st_q <= ST_SET;
            if (step_q == STEP_POLL) begin
              // poll until ready; a suspend also reports ready
              if (rword_q[`FCS_SR_READY]) begin
                st_q <= ST_IDLE;
                busy_q <= 1'b0;
                done_q <= 1'b1;
                // supply, program, wipe or bad-confirm failures
                err_q <= rword_q[`FCS_SR_SUPPLY] | rword_q[`FCS_SR_PROG] |
                  rword_q[`FCS_SR_WIPE];
              end
            end else if (cyc_end && cyc_poll) begin
              step_q <= STEP_POLL;
            end else if (cyc_end) begin
              st_q <= ST_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end else begin
              step_q <= step_q + 2'h1;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // start while busy is refused and sticky; the set beats the clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      refused_q <= 1'b0;
    end else if (start && busy_q) begin
      refused_q <= 1'b1;
    end else if (reg_wr && reg_addr == `FCS_REG_STAT && reg_wdata[3]) begin
      refused_q <= 1'b0;
    end
  end

  // read port: data one cycle after the strobe, unmapped reads zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `FCS_REG_CTRL: reg_rdata <= {11'h000, busy_q, op_q};
        `FCS_REG_ADDR_LO: reg_rdata <= addr_lo_q;
        `FCS_REG_ADDR_HI: reg_rdata <= {14'h0000, addr_hi_q};
        `FCS_REG_WDATA: reg_rdata <= wdata_q;
        `FCS_REG_RDATA: reg_rdata <= rword_q;
        `FCS_REG_STAT: reg_rdata <= {srd_q, 4'h0, refused_q, err_q,
          done_q, busy_q};
        `FCS_REG_PINS: reg_rdata <= {11'h000, pins_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

/* File: verif/fcs_ctrl_props.sv */
// strobe and read-port checks for fcs_ctrl
// assumes bind onto the fcs_ctrl ports, one clk
module fcs_ctrl_props (
  input wire clk,
  input wire rst,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire flash_ce_n,
  input wire flash_we_n,
  input wire flash_oe_n,
  input wire [15:0] flash_dq_o,
  input wire flash_dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // write cycles: shape, qualifiers, data hold
  we_width_a: assert property ($fell(flash_we_n) |->
    !flash_we_n [*2] ##1 flash_we_n) else $error("we width");
  we_qual_a: assert property (!flash_we_n |->
    !flash_ce_n && flash_oe_n && flash_dq_oe) else $error("we qual");
  we_data_a: assert property (!flash_we_n |=>
    $stable(flash_dq_o)) else $error("dq moved under we");
  ce_lead_a: assert property ($fell(flash_we_n) |->
    !$past(flash_ce_n)) else $error("ce not ahead of we");
  ce_drop_a: assert property ($rose(flash_we_n) |=>
    flash_ce_n && !flash_dq_oe) else $error("ce not released");
  // reads: no contention, clean release
  oe_bus_a: assert property (!flash_oe_n |->
    !flash_dq_oe && !flash_ce_n && flash_we_n) else $error("oe clash");
  rd_end_a: assert property ($rose(flash_oe_n) |=>
    flash_ce_n) else $error("ce held after read");
  rd_idle_a: assert property (!$past(reg_rd) |->
    reg_rdata == 16'h0000) else $error("rdata not idle");
endmodule
bind fcs_ctrl fcs_ctrl_props u_props (.clk(clk), .rst(rst),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
  .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe));

/* File: verif/fcs_flash_model.sv */
// behavioural boot-block flash, one word of array
// assumes strobes from fcs_ctrl; addresses beyond bit 0 ignored
module fcs_flash_model #(
  parameter int DLY = 400,
  parameter logic [15:0] MFR = 16'h005A, // arbitrary
  parameter logic [15:0] DEV = 16'h00C3 // arbitrary
) (
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic a0,
  input wire logic [15:0] dq_o,
  input wire logic rp_n,
  input wire logic vpp,
  input wire logic byte_n,
  output wire logic [15:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sr, p;
  logic [15:0] mem = 16'hFFFF;
  logic [15:0] q;
  logic [1:0] md;
  logic er;
  int tok;
  ////////////////////////////////////////////////////////////
  // engine timing; a stale token is dropped
  task automatic fin(input int t);
    #(DLY);
    if (t == tok && !sr[6]) sr[7] = 1'b1;
  endtask
  task automatic start(input logic [15:0] v);
    sr[7] = 1'b0;
    mem = v;
    tok++;
    fork fin(tok); join_none
  endtask
  // command latch on we rising edge
  always @(posedge we_n or negedge rp_n) begin
    if (!rp_n) begin
      sr = 8'h80; md = 2'd0; p = 8'h00; er = 1'b0; tok++;
    end else if (!ce_n) begin
      if (!sr[7]) begin
        if (er && dq_o[7:0] == 8'hB0) begin
          sr[7:6] = 2'b11; md = 2'd2;
        end
      end else if (sr[6]) begin
        if (dq_o[7:0] == 8'hD0) begin sr[6] = 1'b0; start(mem); end
        if (dq_o[7:0] == 8'hFF) md = 2'd0;
        if (dq_o[7:0] == 8'h70) md = 2'd2;
      end else if (p != 8'h00) begin
        md = 2'd2;
        if (p == 8'h20 && dq_o[7:0] != 8'hD0) sr[5:4] = 2'b11;
        else if (!(p == 8'h40 &&
          dq_o == (byte_n ? 16'hFFFF : 16'h00FF)) && !sr[3]) begin
          if (!vpp) sr[3] = 1'b1;
          else begin er = p == 8'h20; start(er ? 16'hFFFF : mem & dq_o); end
        end
        p = 8'h00;
      end else case (dq_o[7:0])
        8'hFF: md = 2'd0;
        8'h90: md = 2'd1;
        8'h70: md = 2'd2;
        8'h50: sr[5:3] = 3'b000;
        8'h40, 8'h10: p = 8'h40;
        8'h20: p = 8'h20;
        default: ;
      endcase
    end
  end
  // readout; released bus shows the inverse, not a stale value
  assign q = !sr[7] || md == 2'd2 ? {8'h00, sr & 8'hF8} :
    md == 2'd1 ? (a0 ? DEV : MFR) : mem;
  assign dq_i = (ce_n || oe_n) ? ~q : q;
endmodule

/* File: verif/test_fcs_ctrl.sv */
// self-checking bench for fcs_ctrl with a flash model
// assumes fcs_defs.vh on the include path
`include "fcs_defs.vh"
module test_fcs_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [15:0] MFR = 16'h005A; // arbitrary
  localparam [15:0] DEV = 16'h00C3; // arbitrary
  logic clk = 0, rst = 1, wr_q = 0, rd_q = 0;
  logic [3:0] ad = 0;
  logic [15:0] wd = 0, rdata, dq_o, dq_i;
  logic ce_n, we_n, oe_n, dq_oe, rp_n, vpp, byte_n, rp_hv, wp;
  logic [17:0] fa;
  int n_errors = 0, n_tests = 0, cyc = 0;
  fcs_ctrl dut (.clk(clk), .rst(rst), .reg_addr(ad), .reg_wdata(wd),
    .reg_wr(wr_q), .reg_rd(rd_q), .reg_rdata(rdata), .flash_ce_n(ce_n),
    .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(fa),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i),
    .flash_byte_n(byte_n), .flash_rp_n(rp_n), .flash_rp_hv(rp_hv),
    .flash_vpp_en(vpp), .flash_wp(wp));
  fcs_flash_model #(.DLY(1200), .MFR(MFR), .DEV(DEV)) u_flash (.ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .a0(fa[0]), .dq_o(dq_o), .rp_n(rp_n),
    .vpp(vpp), .byte_n(byte_n), .dq_i(dq_i));
  ////////////////////////////////////////////////////////////
  // clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin n_errors++; conclude(); end
  end
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input [15:0] g, input [15:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // register port; a gap cycle keeps strobes one assignment a step
  task automatic wr(input [3:0] a, input [15:0] d);
    ad <= a; wd <= d; wr_q <= 1'b1;
    @(posedge clk) wr_q <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input [3:0] a, output [15:0] d);
    ad <= a; rd_q <= 1'b1;
    @(posedge clk) rd_q <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic exp_rd(input [3:0] a, input [15:0] e);
    logic [15:0] s;
    rd(a, s);
    chk(s, e);
  endtask
  // start an op, poll until done and idle
  task automatic go(input [3:0] o, input bit w = 1);
    logic [15:0] s;
    if (w) wr(`FCS_REG_CTRL, {12'h000, o});
    for (int i = 0; i < 400; i++) begin
      rd(`FCS_REG_STAT, s);
      if (s[1:0] === 2'b10) return;
    end
    chk(s, 16'h0002);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({14'h0, rp_n, ce_n}, 16'h0003);
    exp_rd(`FCS_REG_PINS, 16'h0009);
    exp_rd(4'hF, 16'h0000);
    go(`FCS_OP_READ);
    exp_rd(`FCS_REG_RDATA, 16'hFFFF);
  endtask
  task automatic t_prog();
    wr(`FCS_REG_WDATA, 16'h1234);
    wr(`FCS_REG_CTRL, {12'h000, `FCS_OP_PROG});
    go(`FCS_OP_READ);
    exp_rd(`FCS_REG_STAT, 16'h800A);
    wr(`FCS_REG_STAT, 16'h0008);
    go(`FCS_OP_READ);
    exp_rd(`FCS_REG_RDATA, 16'h0080);
    go(`FCS_OP_ARRAY);
    for (int i = 0; i < 2; i++) begin
      go(`FCS_OP_READ);
      exp_rd(`FCS_REG_RDATA, 16'h1234);
    end
  endtask
  task automatic t_cancel();
    wr(`FCS_REG_WDATA, 16'h0000);
    go(`FCS_OP_CANCEL);
    go(`FCS_OP_ARRAY);
    go(`FCS_OP_READ);
    exp_rd(`FCS_REG_RDATA, 16'h1234);
  endtask
  // byte bus: null program uses the low byte only; pins follow PINS
  task automatic t_pins();
    wr(`FCS_REG_PINS, 16'h001E);
    #1 chk({11'h000, rp_hv, rp_n, wp, vpp, byte_n}, 16'h001E);
    @(posedge clk);
    exp_rd(`FCS_REG_PINS, 16'h001E);
    go(`FCS_OP_CANCEL);
    go(`FCS_OP_ARRAY);
    go(`FCS_OP_READ);
    exp_rd(`FCS_REG_RDATA, 16'h1234);
    wr(`FCS_REG_PINS, 16'h0009);
  endtask
  task automatic t_ident();
    for (int i = 0; i < 2; i++) begin
      wr(`FCS_REG_ADDR_LO, i[15:0]);
      go(`FCS_OP_IDENT);
      exp_rd(`FCS_REG_RDATA, i ? DEV : MFR);
    end
  endtask
  task automatic t_bad();
    wr(`FCS_REG_WDATA, 16'h0020);
    go(`FCS_OP_WRITE);
    wr(`FCS_REG_WDATA, 16'h0000);
    go(`FCS_OP_WRITE);
    go(`FCS_OP_STATUS);
    exp_rd(`FCS_REG_RDATA, 16'h00B0);
    // a polled op now ends with the sticky failure bits in err
    go(`FCS_OP_SUSP);
    exp_rd(`FCS_REG_STAT, 16'hB006);
    go(`FCS_OP_CLEAR);
    go(`FCS_OP_STATUS);
    exp_rd(`FCS_REG_RDATA, 16'h0080);
  endtask
  task automatic t_erase();
    wr(`FCS_REG_ADDR_HI, 16'h0003);
    wr(`FCS_REG_ADDR_LO, 16'hF000);
    #1 chk({10'h000, fa[17:12]}, 16'h003F);
    @(posedge clk);
    go(`FCS_OP_ERASE);
    go(`FCS_OP_ARRAY);
    go(`FCS_OP_READ);
    exp_rd(`FCS_REG_RDATA, 16'hFFFF);
  endtask
  task automatic t_susp();
    logic [15:0] s;
    wr(`FCS_REG_PINS, 16'h000B);
    wr(`FCS_REG_WDATA, 16'h0020);
    go(`FCS_OP_WRITE);
    wr(`FCS_REG_WDATA, 16'h00D0);
    go(`FCS_OP_WRITE);
    go(`FCS_OP_SUSP);
    rd(`FCS_REG_STAT, s);
    chk({8'h00, s[15:8]}, 16'h00C0);
    go(`FCS_OP_RESUME);
    go(`FCS_OP_STATUS);
    exp_rd(`FCS_REG_RDATA, 16'h0000);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // pins launch on the first edge after release: look one edge later
    repeat (2) @(posedge clk);
    t_reset();
    t_prog();
    t_cancel();
    t_pins();
    t_ident();
    t_bad();
    t_erase();
    t_susp();
    conclude();
  end
endmodule
